/* anp_params.svh */
/*
  Constants for the partner-ability / next-page management register subset:
  register addresses, field positions, reset values, frame layout, timing.
  Assumes it is included by bare name from every file that needs it.
*/
`ifndef ANP_PARAMS_SVH
`define ANP_PARAMS_SVH

// register addresses on the management interface
`define ANP_REG_PARTNER 5'h05
`define ANP_REG_EXPAND 5'h06
`define ANP_REG_NPTX 5'h07

// reset values
`define ANP_PARTNER_RST 16'h0001
`define ANP_NPTX_RST 16'h2001

// base layout bits 12:11 are reserved and read as zero
`define ANP_BASE_RSVD_MASK 16'h1800
// bit 14 of the next page transmit word is reserved
`define ANP_NPTX_WMASK 16'hbfff

// field positions
`define ANP_NP_BIT 15
`define ANP_TOGGLE_BIT 11
`define ANP_EXP_WIDTH 11

// management frame encoding
`define ANP_OP_READ 2'b10
`define ANP_OP_WRITE 2'b01
`define ANP_PREAMBLE_LEN 6'h20
`define ANP_HDR_LAST 5'h0b
`define ANP_DATA_LAST 5'h0f
`define ANP_FRAME_LAST 6'h3f
`define ANP_TA_FIRST 6'h2e
`define ANP_DATA_FIRST 6'h30

// partner must repeat a burst this many times before we acknowledge
`define ANP_ACK_COUNT 2'h3

// management clock half period in mclk cycles (50 MHz / 16 = 3.125 MHz)
`define ANP_MDC_HALF 8

`endif

/* anp_pkg.sv */
/*
  Types shared by both ends of the management link: state encodings.
  Assumes anp_params.svh is on the include path.
*/
`default_nettype none

package anp_pkg;

	// device-end frame receiver states
	typedef enum logic [4:0]
	{
		ANP_D_HUNT = 5'b00001,
		ANP_D_START = 5'b00010,
		ANP_D_HDR = 5'b00100,
		ANP_D_TURN = 5'b01000,
		ANP_D_DATA = 5'b10000
	} anp_dev_state_e;

	// host-end frame sender states
	typedef enum logic [1:0]
	{
		ANP_H_IDLE = 2'b01,
		ANP_H_RUN = 2'b10
	} anp_host_state_e;

endpackage

`default_nettype wire

/* anp_mgmt_if.sv */
/*
  Management serial link between the station host and the device.
  The data line is shared: each end drives out and enable, and the
  resolved level idles high as through a pull-up.
*/
`timescale 1ns/1ns
`default_nettype none

interface anp_mgmt_if;
	logic mdc;
	logic host_mdio_out;
	logic host_mdio_oe;
	logic dev_mdio_out;
	logic dev_mdio_oe;
	logic mdio;

	// wire level from the two enables; pull-up when nobody drives
	assign mdio = host_mdio_oe ? host_mdio_out : (dev_mdio_oe ? dev_mdio_out : 1'b1);

	modport host (output mdc, output host_mdio_out, output host_mdio_oe, input mdio);
	modport dev (input mdc, output dev_mdio_out, output dev_mdio_oe, input mdio);
endinterface

`default_nettype wire

/* anp_dev_end.sv */
/*
  Device end: partner ability word, expansion flags and next page
  transmit word, reached over the management serial link.
  Assumes the negotiation engine drives the user-side inputs on mclk,
  and the host follows the standard frame with preamble.
*/
// How it works
// - base page: np, ack, fault in 15-13
// - base page abilities in bits 10 to 5
// - base page selector bits 4:0, reset 00001
// - base page bits 12:11 reserved, read-only
// - next page: mp, comply_acknowledge, toggle, message code
// - parallel fault latches, read clears, 15:5 zero
// - bit 3 shows partner next page ability
// - bit 2 always reads one
// - page received latches, read clears it
// - bit 0 shows partner negotiation ability
// - transmit bit 15 host-writable more pages request
// - transmit bit 13 message page select, reset one
// - transmit bit 12 comply acknowledge, reset zero
// - transmit bit 11 outgoing toggle, inverts after send
// - transmit code 10:0 reset 001, bit 14 zero
// - host never writes reserved addresses
// - partner contents valid only after completion
// - own ack after three matching bursts
`timescale 1ns/1ns
`default_nettype none
`include "anp_params.svh"

module anp_dev_end
	import anp_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = 5'h01
)
(
	input wire logic mclk,
	input wire logic reset,
	anp_mgmt_if.dev mgmt,
	input wire logic [15:0] lp_word,
	input wire logic lp_word_valid,
	input wire logic an_restart,
	input wire logic an_complete,
	input wire logic lp_an_able,
	input wire logic par_fault,
	input wire logic [15:0] burst_word,
	input wire logic burst_valid,
	input wire logic np_sent,
	output logic [15:0] np_tx_word,
	output logic local_ack,
	output logic lp_layout_next
);

	logic [2:0] mdc_s_q;
	logic [2:0] mdio_s_q;
	logic mdc_lvl_q;
	logic mdio_lvl_q;
	logic rise;
	anp_dev_state_e state_q;
	logic [5:0] ones_q;
	logic [4:0] bit_q;
	logic [10:0] hdr_q;
	logic [11:0] hdr_full;
	logic hdr_hit;
	logic is_read_q;
	logic [4:0] reg_q;
	logic [15:0] wr_sh_q;
	logic [15:0] rd_sh_q;
	logic mdio_out_q;
	logic mdio_oe_q;
	logic rd_capture;
	logic exp_read;
	logic wr_commit;
	logic [15:0] wr_data;
	logic [15:0] lp_word_q;
	logic word_next_q;
	logic base_seen_q;
	logic page_rx_q;
	logic pdf_q;
	logic lp_np_able_q;
	logic lp_an_able_q;
	logic [15:0] nptx_q;
	logic [15:0] last_burst_q;
	logic [1:0] burst_cnt_q;
	logic ack_q;
	logic [15:0] partner_view;
	logic [15:0] expand_view;
	logic [15:0] read_value;

	assign mgmt.dev_mdio_out = mdio_out_q;
	assign mgmt.dev_mdio_oe = mdio_oe_q;
	assign np_tx_word = nptx_q;
	assign local_ack = ack_q;
	assign lp_layout_next = word_next_q;

	// three-stage synchronisers; a level counts once stages two and three agree
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			mdc_s_q <= 3'h0;
			mdio_s_q <= 3'h7;
			mdc_lvl_q <= 1'b0;
			mdio_lvl_q <= 1'b1;
		end
		else
		begin
			mdc_s_q <= {mdc_s_q[1:0], mgmt.mdc};
			mdio_s_q <= {mdio_s_q[1:0], mgmt.mdio};
			if (mdc_s_q[1] == mdc_s_q[2])
				mdc_lvl_q <= mdc_s_q[2];
			if (mdio_s_q[1] == mdio_s_q[2])
				mdio_lvl_q <= mdio_s_q[2];
		end
	end

	assign rise = (mdc_s_q[1] == mdc_s_q[2]) && mdc_s_q[2] && !mdc_lvl_q;
	assign hdr_full = {hdr_q, mdio_lvl_q};
	assign hdr_hit = (hdr_full[9:5] == PHY_ADDR)
		&& ((hdr_full[11:10] == `ANP_OP_READ) || (hdr_full[11:10] == `ANP_OP_WRITE));
	assign rd_capture = rise && (state_q == ANP_D_HDR) && (bit_q == `ANP_HDR_LAST)
		&& hdr_hit && (hdr_full[11:10] == `ANP_OP_READ);
	assign exp_read = rd_capture && (hdr_full[4:0] == `ANP_REG_EXPAND);
	assign wr_data = {wr_sh_q[14:0], mdio_lvl_q};
	assign wr_commit = rise && (state_q == ANP_D_DATA) && (bit_q == `ANP_DATA_LAST) && !is_read_q;

	// frame receiver: preamble, start, header, turnaround, data
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state_q <= ANP_D_HUNT;
			ones_q <= 6'h00;
			bit_q <= 5'h00;
			hdr_q <= 11'h000;
			is_read_q <= 1'b0;
			reg_q <= 5'h00;
			wr_sh_q <= 16'h0000;
		end
		else if (rise)
		begin
			case (state_q)
				ANP_D_HUNT:
				begin
					if (mdio_lvl_q)
						ones_q <= (ones_q == `ANP_PREAMBLE_LEN) ? ones_q : ones_q + 6'h01;
					else
					begin
						ones_q <= 6'h00;
						if (ones_q == `ANP_PREAMBLE_LEN)
							state_q <= ANP_D_START;
					end
				end
				ANP_D_START:
				begin
					state_q <= mdio_lvl_q ? ANP_D_HDR : ANP_D_HUNT;
					bit_q <= 5'h00;
				end
				ANP_D_HDR:
				begin
					hdr_q <= hdr_full[10:0];
					bit_q <= bit_q + 5'h01;
					if (bit_q == `ANP_HDR_LAST)
					begin
						// frames for another address are ignored; 18 bits cannot fake a preamble
						state_q <= hdr_hit ? ANP_D_TURN : ANP_D_HUNT;
						is_read_q <= (hdr_full[11:10] == `ANP_OP_READ);
						reg_q <= hdr_full[4:0];
						bit_q <= 5'h00;
					end
				end
				ANP_D_TURN:
				begin
					bit_q <= bit_q + 5'h01;
					if (bit_q == 5'h01)
					begin
						state_q <= ANP_D_DATA;
						bit_q <= 5'h00;
					end
				end
				ANP_D_DATA:
				begin
					wr_sh_q <= wr_data;
					bit_q <= bit_q + 5'h01;
					if (bit_q == `ANP_DATA_LAST)
						state_q <= ANP_D_HUNT;
				end
				default:
					state_q <= ANP_D_HUNT;
			endcase
		end
	end

	// partner word as read; stays at its reset value until completion
	always_comb
	begin
		partner_view = lp_word_q;
		if (!an_complete)
			partner_view = `ANP_PARTNER_RST;
		else if (!word_next_q)
			partner_view = lp_word_q & ~`ANP_BASE_RSVD_MASK;
	end

	// expansion flags: upper bits zero, own next page ability tied high
	assign expand_view = {{`ANP_EXP_WIDTH{1'b0}}, pdf_q, lp_np_able_q, 1'b1, page_rx_q,
		lp_an_able_q};

	// read mux; unmapped and reserved addresses read zero
	always_comb
	begin
		case (hdr_full[4:0])
			`ANP_REG_PARTNER: read_value = partner_view;
			`ANP_REG_EXPAND: read_value = expand_view;
			`ANP_REG_NPTX: read_value = nptx_q;
			default: read_value = 16'h0000;
		endcase
	end

	// read data driver: zero in the second turnaround bit, then msb first
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			rd_sh_q <= 16'h0000;
			mdio_out_q <= 1'b1;
			mdio_oe_q <= 1'b0;
		end
		else if (rise)
		begin
			if (rd_capture)
				rd_sh_q <= read_value;
			else if (is_read_q && state_q == ANP_D_TURN && bit_q == 5'h00)
			begin
				mdio_oe_q <= 1'b1;
				mdio_out_q <= 1'b0;
			end
			else if (is_read_q && ((state_q == ANP_D_TURN)
				|| (state_q == ANP_D_DATA && bit_q != `ANP_DATA_LAST)))
			begin
				mdio_out_q <= rd_sh_q[15];
				rd_sh_q <= {rd_sh_q[14:0], 1'b0};
			end
			else
			begin
				mdio_oe_q <= 1'b0;
				mdio_out_q <= 1'b1;
			end
		end
	end

	// partner word store; first word after restart is the base page
	always_ff @(posedge mclk)
	begin
		if (reset || an_restart)
		begin
			lp_word_q <= `ANP_PARTNER_RST;
			word_next_q <= 1'b0;
			base_seen_q <= 1'b0;
			lp_np_able_q <= 1'b0;
		end
		else if (lp_word_valid)
		begin
			lp_word_q <= lp_word;
			word_next_q <= base_seen_q;
			base_seen_q <= 1'b1;
			if (!base_seen_q)
				lp_np_able_q <= lp_word[`ANP_NP_BIT];
		end
	end

	// latched flags: a new event in the clearing read cycle survives
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			page_rx_q <= 1'b0;
			pdf_q <= 1'b0;
			lp_an_able_q <= 1'b0;
		end
		else
		begin
			page_rx_q <= lp_word_valid | (page_rx_q & ~exp_read);
			pdf_q <= par_fault | (pdf_q & ~exp_read);
			lp_an_able_q <= lp_an_able;
		end
	end

	// next page transmit word; hardware toggle update beats a same-cycle write
	always_ff @(posedge mclk)
	begin
		if (reset)
			nptx_q <= `ANP_NPTX_RST;
		else
		begin
			if (wr_commit && reg_q == `ANP_REG_NPTX)
				nptx_q <= wr_data & `ANP_NPTX_WMASK;
			if (np_sent)
				nptx_q[`ANP_TOGGLE_BIT] <= ~nptx_q[`ANP_TOGGLE_BIT];
		end
	end

	// own acknowledge after the same burst arrives three times running
	always_ff @(posedge mclk)
	begin
		if (reset || an_restart)
		begin
			last_burst_q <= 16'h0000;
			burst_cnt_q <= 2'h0;
			ack_q <= 1'b0;
		end
		else if (burst_valid)
		begin
			last_burst_q <= burst_word;
			if (burst_cnt_q != 2'h0 && burst_word == last_burst_q)
			begin
				if (burst_cnt_q != `ANP_ACK_COUNT)
					burst_cnt_q <= burst_cnt_q + 2'h1;
				if (burst_cnt_q == `ANP_ACK_COUNT - 2'h1)
					ack_q <= 1'b1;
			end
			else
				burst_cnt_q <= 2'h1;
		end
	end

endmodule

`default_nettype wire

/* anp_host_end.sv */
/*
  Host end: turns register read/write commands into management frames,
  generating the management clock from mclk.
  Assumes the device end answers reads in the standard frame timing.
*/
`timescale 1ns/1ns
`default_nettype none
`include "anp_params.svh"

module anp_host_end
	import anp_pkg::*;
#(
	parameter int MDC_HALF = `ANP_MDC_HALF
)
(
	input wire logic mclk,
	input wire logic reset,
	anp_mgmt_if.host mgmt,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [4:0] cmd_phy,
	input wire logic [4:0] cmd_reg,
	input wire logic [15:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_rdata
);

	anp_host_state_e state_q;
	logic [2:0] mdio_s_q;
	logic mdio_lvl_q;
	logic [7:0] div_q;
	logic mdc_q;
	logic [63:0] frame_q;
	logic [5:0] bit_q;
	logic write_q;
	logic out_q;
	logic oe_q;
	logic [15:0] rd_q;
	logic rsp_valid_q;
	logic [15:0] rsp_rdata_q;
	logic reserved;
	logic tick;

	assign mgmt.mdc = mdc_q;
	assign mgmt.host_mdio_out = out_q;
	assign mgmt.host_mdio_oe = oe_q;
	// one-hot idle bit, so ready comes straight from the state flop
	assign cmd_ready = state_q[0];
	assign rsp_valid = rsp_valid_q;
	assign rsp_rdata = rsp_rdata_q;
	assign tick = (div_q == 8'(MDC_HALF - 1));

	// reserved addresses are never put on the wire
	assign reserved = (cmd_reg >= 5'h08 && cmd_reg <= 5'h0f) || (cmd_reg == 5'h14)
		|| (cmd_reg == 5'h16) || (cmd_reg >= 5'h19);

	// read data from the pin passes four flops before use
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			mdio_s_q <= 3'h7;
			mdio_lvl_q <= 1'b1;
		end
		else
		begin
			mdio_s_q <= {mdio_s_q[1:0], mgmt.mdio};
			if (mdio_s_q[1] == mdio_s_q[2])
				mdio_lvl_q <= mdio_s_q[2];
		end
	end

	// frame sender: data changes on falling mdc, sampled on rising mdc
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state_q <= ANP_H_IDLE;
			div_q <= 8'h00;
			mdc_q <= 1'b0;
			frame_q <= 64'h0;
			bit_q <= 6'h00;
			write_q <= 1'b0;
			out_q <= 1'b1;
			oe_q <= 1'b0;
			rd_q <= 16'h0000;
			rsp_valid_q <= 1'b0;
			rsp_rdata_q <= 16'h0000;
		end
		else
		begin
			rsp_valid_q <= 1'b0;
			case (state_q)
				ANP_H_IDLE:
				begin
					if (cmd_valid && reserved)
					begin
						// refused: answered at once, read value is disregarded as zero
						rsp_valid_q <= 1'b1;
						rsp_rdata_q <= 16'h0000;
					end
					else if (cmd_valid)
					begin
						frame_q <= {32'hffffffff, 2'b01,
							cmd_write ? `ANP_OP_WRITE : `ANP_OP_READ, cmd_phy, cmd_reg,
							cmd_write ? 2'b10 : 2'b11, cmd_write ? cmd_wdata : 16'hffff};
						write_q <= cmd_write;
						bit_q <= 6'h00;
						div_q <= 8'h00;
						mdc_q <= 1'b0;
						out_q <= 1'b1;
						oe_q <= 1'b1;
						state_q <= ANP_H_RUN;
					end
				end
				ANP_H_RUN:
				begin
					div_q <= tick ? 8'h00 : div_q + 8'h01;
					if (tick)
					begin
						mdc_q <= ~mdc_q;
						if (!mdc_q && !write_q && bit_q >= `ANP_DATA_FIRST)
							rd_q <= {rd_q[14:0], mdio_lvl_q};
						if (mdc_q && bit_q == `ANP_FRAME_LAST)
						begin
							oe_q <= 1'b0;
							out_q <= 1'b1;
							rsp_valid_q <= 1'b1;
							rsp_rdata_q <= write_q ? 16'h0000 : rd_q;
							state_q <= ANP_H_IDLE;
						end
						else if (mdc_q)
						begin
							bit_q <= bit_q + 6'h01;
							frame_q <= {frame_q[62:0], 1'b0};
							out_q <= frame_q[62];
							// a read releases the line for turnaround and data
							oe_q <= write_q || (bit_q + 6'h01 < `ANP_TA_FIRST);
						end
					end
				end
				default:
					state_q <= ANP_H_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

/* anp_link_assertions.sv */
/*
  Checker for the management link between the host and device ends.
  Assumes it sits beside the link interface and mdc toggles every 8 mclk.
*/
`timescale 1ns/1ns
`default_nettype none

module anp_link_assertions
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic mdc,
	input wire logic host_mdio_out,
	input wire logic host_mdio_oe,
	input wire logic dev_mdio_out,
	input wire logic dev_mdio_oe,
	input wire logic mdio
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// wide enough for a full 64-bit write frame of 1024 cycles
	logic [10:0] oe_cnt_q;

	// length of each host drive stretch; a header cut short would misaddress
	always_ff @(posedge mclk)
	begin
		if (reset || !host_mdio_oe)
			oe_cnt_q <= 11'h000;
		else
			oe_cnt_q <= oe_cnt_q + 11'h001;
	end

	a_no_contention: assert property (!(host_mdio_oe && dev_mdio_oe))
		else $error("both ends drive the data line");
	a_idle_high: assert property (!host_mdio_oe && !dev_mdio_oe |-> mdio)
		else $error("released data line is not high");
	a_mdc_high_half: assert property ($rose(mdc) |-> mdc[*8] ##1 !mdc)
		else $error("mdc high phase has the wrong length");
	a_mdc_low_half: assert property ($fell(mdc) |-> !mdc[*8])
		else $error("mdc low phase too short");
	a_host_out_fall: assert property ($past(host_mdio_oe) && host_mdio_oe
		&& $changed(host_mdio_out) |-> $fell(mdc))
		else $error("host data changed away from falling mdc");
	a_dev_stable_fall: assert property ($fell(mdc) && $past(dev_mdio_oe) |->
		$stable(dev_mdio_out))
		else $error("device data changed on falling mdc");
	a_dev_turn_zero: assert property ($rose(dev_mdio_oe) |-> !dev_mdio_out)
		else $error("device turnaround bit is not zero");
	a_dev_release: assert property ($rose(dev_mdio_oe) |-> ##[240:300] $fell(dev_mdio_oe))
		else $error("device drive stretch has the wrong length");
	a_host_drive_len: assert property ($fell(host_mdio_oe) |->
		oe_cnt_q inside {[11'h2bc:11'h2f8], [11'h3e8:11'h41a]})
		else $error("host header stretch has the wrong length");
endmodule

`default_nettype wire

/* autoneg_partner_nextpage_regs_tb.sv */
/*
  Bench: host and device ends joined over the link, with a register model.
  Assumes the design files and anp_params.svh are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "anp_params.svh"

`define CHK(nm, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			failures++; \
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
		end \
	end

module autoneg_partner_nextpage_regs_tb;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [4:0] cmd_phy = 5'h01;
	logic [4:0] cmd_reg = 5'h00;
	logic [15:0] cmd_wdata = 16'h0000;
	logic cmd_ready, rsp_valid, local_ack, lp_layout_next;
	logic [15:0] rsp_rdata, np_tx_word, w, v;
	logic [15:0] lp_word = 16'h0000;
	logic [15:0] burst_word = 16'h0000;
	logic [4:0] pv = 5'h00;
	logic an_complete = 1'b0;
	logic lp_an_able = 1'b0;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int m_pf = 0, m_pr = 0, m_npa = 0, m_able = 0, m_ack = 0, cnt = 0;
	logic [15:0] m_nptx = 16'h2001;
	int rsvd[$] = '{8, 9, 10, 11, 12, 13, 14, 15, 20, 22, 25, 26, 27, 28, 29, 30, 31};

	anp_mgmt_if u_anp_mgmt_if();
	anp_host_end #(.MDC_HALF(8)) u_anp_host_end(.mclk(mclk), .reset(reset),
		.mgmt(u_anp_mgmt_if), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_phy(cmd_phy), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
	anp_dev_end #(.PHY_ADDR(5'h01)) u_anp_dev_end(.mclk(mclk), .reset(reset),
		.mgmt(u_anp_mgmt_if), .lp_word(lp_word), .lp_word_valid(pv[0]),
		.an_restart(pv[4]), .an_complete(an_complete), .lp_an_able(lp_an_able),
		.par_fault(pv[2]), .burst_word(burst_word), .burst_valid(pv[1]),
		.np_sent(pv[3]), .np_tx_word(np_tx_word), .local_ack(local_ack),
		.lp_layout_next(lp_layout_next));
	anp_link_assertions u_anp_link_assertions(.mclk(mclk), .reset(reset),
		.mdc(u_anp_mgmt_if.mdc), .host_mdio_out(u_anp_mgmt_if.host_mdio_out),
		.host_mdio_oe(u_anp_mgmt_if.host_mdio_oe), .dev_mdio_out(u_anp_mgmt_if.dev_mdio_out),
		.dev_mdio_oe(u_anp_mgmt_if.dev_mdio_oe), .mdio(u_anp_mgmt_if.mdio));

	// 50 MHz clock
	always #10 mclk = ~mclk;

	// hang guard; the whole run needs roughly 26k cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one-cycle pulse on a user-side strobe: 0 word, 1 burst, 2 fault, 3 sent, 4 restart
	task automatic pulse(input int k);
		pv[k] <= 1'b1;
		@(posedge mclk);
		pv[k] <= 1'b0;
		@(posedge mclk);
	endtask

	// one command, held for a single cycle, then wait for the response pulse
	task automatic xfer(input logic wr, input logic [4:0] ra, input logic [15:0] wd);
		int n;
		n = 0;
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_reg <= ra;
		cmd_wdata <= wd;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (rsp_valid !== 1'b1 && n < 3000);
		v = rsp_rdata;
		if (n >= 3000)
			`CHK("rsp_valid", 1'b1, rsp_valid)
		@(posedge mclk);
	endtask

	task automatic rd_chk(input logic [4:0] ra, input logic [15:0] e, input string nm);
		xfer(1'b0, ra, 16'h0000);
		`CHK(nm, e, v)
	endtask

	// expansion read returns the latched flags, then the model drops them
	task automatic rd_exp(input string nm);
		rd_chk(5'h06, {11'h000, m_pf[0], m_npa[0], 1'b1, m_pr[0], m_able[0]}, nm);
		m_pf = 0;
		m_pr = 0;
	endtask

	// base page word arrives: reserved 12:11 masked, bit 15 gives next page ability
	task automatic base_page();
		w = 16'($urandom()) | 16'h9800;
		lp_word <= w;
		pulse(0);
		m_npa = w[15];
		m_pr = 1;
		rd_chk(5'h05, w & 16'he7ff, "base page");
		`CHK("layout", 1'b0, lp_layout_next)
	endtask

	initial
	begin
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		void'($urandom(48807));
		`CHK("np_tx_word", 16'h2001, np_tx_word)
		rd_chk(5'h07, 16'h2001, "nptx reset");
		rd_chk(5'h05, 16'h0001, "partner reset");
		rd_exp("expand reset");
		$display("test reset values done");
		an_complete <= 1'b1;
		lp_an_able <= 1'b1;
		m_able = 1;
		base_page();
		rd_exp("expand base");
		for (int i = 0; i < 3; i++)
		begin
			w = 16'($urandom());
			lp_word <= w;
			pulse(0);
			m_pr = 1;
			if (i == 1)
				pulse(2);
			m_pf = (i == 1);
			rd_chk(5'h05, w, "next page");
			`CHK("layout", 1'b1, lp_layout_next)
			rd_exp("expand next");
		end
		$display("test partner pages done");
		for (int i = 0; i < 4; i++)
		begin
			w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom());
			xfer(1'b1, 5'h07, w);
			m_nptx = w & 16'hbfff;
			rd_chk(5'h07, m_nptx, "nptx write");
			pulse(3);
			m_nptx ^= 16'h0800;
			`CHK("toggle", m_nptx, np_tx_word)
		end
		$display("test transmit word done");
		foreach (rsvd[i])
		begin
			xfer(1'b1, 5'(rsvd[i]), 16'hffff);
			rd_chk(5'(rsvd[i]), 16'h0000, "reserved read");
		end
		rd_chk(5'h07, m_nptx, "nptx kept");
		rd_chk(5'h04, 16'h0000, "unmapped read");
		$display("test reserved space done");
		w = 16'($urandom());
		for (int i = 0; i < 6; i++)
		begin
			burst_word <= (i == 2) ? ~w : w;
			pulse(1);
			cnt = (i == 2 || i == 3) ? 1 : cnt + 1;
			m_ack = m_ack | (cnt >= 3);
			`CHK("local_ack", m_ack[0], local_ack)
		end
		$display("test acknowledge done");
		pulse(4);
		m_npa = 0;
		rd_chk(5'h05, 16'h0001, "after restart");
		base_page();
		an_complete <= 1'b0;
		lp_an_able <= 1'b0;
		m_able = 0;
		@(posedge mclk);
		rd_chk(5'h05, 16'h0001, "incomplete");
		rd_exp("expand not able");
		$display("test restart done");
		tally_and_finish();
	end
endmodule

`default_nettype wire
